/* hw/pwm_gen_capture_timer.sv */
// Eight-channel pulse generator with dead-zone pairs and input capture, AHB-Lite slave.
//
// Functional notes
// R1: Four generators of two channels give eight outputs or four complementary pairs.
// R2: Each generator has 8-bit prescaler, per-channel divider by 1, 2, 4, 8 or 16.
// R3: Each channel has a 16-bit period down counter and 16-bit duty comparator.
// R4: Each channel sets its own flag when its period counter reaches zero.
// R5: Interrupt raised only for a set flag whose enable bit is set.
// R6: Auto-reload mode reloads period at zero and keeps counting down.
// R7: One-shot mode halts at zero after one flag, one output cycle.
// R8: Pair 0/1 enable at control bit 4 drives both from channel 0 timer.
// R9: Pairs 2/3, 4/5, 6/7 use timers and dead-zones 2, 4, 6.
// R10: Period and compare writes go to buffers, loaded when counter reaches zero.
// R11: Output goes high when counter equals compare value.
// R12: Capture enable turns the pin to input using the same-index timer.
// R13: Rising edges latch counter into rising latch, falling edges into falling latch.
// R14: Per channel rising and falling interrupt enables select which edges interrupt.
// R15: A capture interrupt reloads that channel's counter at that moment.
// R16: Software configures the timer before enabling capture.
// R17: Writing one to a flag clears it; software reads flags and latches first.
// R18: Complementary odd output inverts even; each rising edge delayed by dead time.
`timescale 1ns/1ps
`default_nettype none

module pwm_gen_capture_timer
  import pwm_pkg::*;
(
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  input  wire logic [NUM_CH-1:0]  capture_in,
  output logic [NUM_CH-1:0]       pulse_outputs_0_to_7,
  output logic [NUM_CH-1:0]       pulse_oe_n,
  output logic                    irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NUM_GEN-1:0]                dz_en;
    logic [NUM_CH-1:0]                 run;
    logic [NUM_CH-1:0]                 auto_reload;
    logic [NUM_GEN-1:0][PRE_W-1:0]     prescale;
    logic [NUM_CH-1:0][SEL_W-1:0]      clk_sel;
    logic [NUM_GEN-1:0][DEAD_W-1:0]    dead;
    logic [NUM_CH-1:0][CNT_W-1:0]      period_buf;
    logic [NUM_CH-1:0][CNT_W-1:0]      cmp_buf;
    logic [NUM_CH-1:0][CNT_W-1:0]      period_reload_value;
    logic [NUM_CH-1:0][CNT_W-1:0]      cmp_act;
    logic [NUM_CH-1:0][CNT_W-1:0]      cnt;
    logic [NUM_CH-1:0]                 armed;
    logic [NUM_CH-1:0]                 halted;
    logic [NUM_CH-1:0]                 raw;
    logic [NUM_GEN-1:0][PRE_W-1:0]     pre_cnt;
    logic [NUM_GEN-1:0][DIV_W-1:0]     div_cnt;
    logic [NUM_CH-1:0][2:0]            cap_ctrl;
    logic [NUM_CH-1:0][CNT_W-1:0]      rising_capture_latch;
    logic [NUM_CH-1:0][CNT_W-1:0]      falling_capture_latch;
    logic [NUM_CH-1:0]                 sync1;
    logic [NUM_CH-1:0]                 sync2;
    logic [NUM_CH-1:0]                 sync3;
    logic [NUM_CH-1:0]                 cap_lvl;
    logic [STAT_W-1:0]                 status;
    logic [STAT_W-1:0]                 mask;
    logic [NUM_GEN-1:0][DEAD_W-1:0]    dz_cnt;
    logic [NUM_GEN-1:0]                dz_prev;
    logic [NUM_CH-1:0]                 pin_out;
    logic                              ap_valid;
    logic                              ap_write;
    logic [ADDR_W-1:0]                 ap_addr;
    logic                              rd_pend;
    logic [31:0]                       rdata;
  } state_s;

  state_s cur;
  state_s next_s;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------

  // All channel, capture, dead-zone and bus behaviour in one pass.
  always_comb begin
    logic [NUM_GEN-1:0]  pre_tick;
    logic [NUM_CH-1:0]   ch_tick;
    logic [NUM_CH-1:0]   cap_evt;
    logic [NUM_CH-1:0]   rise;
    logic [NUM_CH-1:0]   fall;
    logic [STAT_W-1:0]   set_flags;
    logic [STAT_W-1:0]   clr_flags;
    logic [4:0]          dmask;
    logic [SEL_W-1:0]    sel;
    logic                wr;
    logic [ADDR_W-1:0]   a;
    logic [2:0]          pch;
    logic [2:0]          lch;
    logic [31:0]         rd_word;
    logic                base;
    int                  bit_pos;
    pre_tick  = '0;
    ch_tick   = '0;
    cap_evt   = '0;
    rise      = '0;
    fall      = '0;
    set_flags = '0;
    clr_flags = '0;
    dmask     = '0;
    sel       = '0;
    rd_word   = '0;
    base      = 1'b0;
    bit_pos   = 0;
    next_s    = cur;
    a         = cur.ap_addr;
    wr        = cur.ap_valid && cur.ap_write;
    pch       = 3'((a - OFF_PERIOD0) >> CH_SHIFT);
    lch       = 3'((a - OFF_LATCH0) >> LAT_SHIFT);

    // Prescaler divides by value plus one, then the per-generator divide chain counts.
    for (int g = 0; g < NUM_GEN; g++) begin
      if (cur.pre_cnt[g] == '0) begin
        pre_tick[g]       = 1'b1; // R2
        next_s.pre_cnt[g] = cur.prescale[g];
        next_s.div_cnt[g] = cur.div_cnt[g] + 4'h1;
      end else begin
        next_s.pre_cnt[g] = cur.pre_cnt[g] - 8'h01;
      end
    end

    // Divider select per channel picks a tick once every 1, 2, 4, 8 or 16 prescaler ticks.
    for (int c = 0; c < NUM_CH; c++) begin
      sel   = (cur.clk_sel[c] > DIV_MAX_SEL) ? DIV_MAX_SEL : cur.clk_sel[c];
      dmask = (5'h01 << sel) - 5'h01;
      ch_tick[c] = pre_tick[c/2] &&
                   ((cur.div_cnt[c/2] & dmask[3:0]) == dmask[3:0]); // R2
    end

    // Capture pins pass three flops; an edge counts once the last two agree on a change.
    next_s.sync1 = capture_in;
    next_s.sync2 = cur.sync1;
    next_s.sync3 = cur.sync2;
    for (int c = 0; c < NUM_CH; c++) begin
      // The accepted level follows the pin only while the last two stages agree.
      if (cur.sync2[c] == cur.sync3[c]) begin
        next_s.cap_lvl[c] = cur.sync3[c];
      end
      if (cur.cap_ctrl[c][CAP_EN_BIT]) begin
        rise[c] = (cur.sync2[c] == cur.sync3[c]) && cur.sync3[c] && !cur.cap_lvl[c];
        fall[c] = (cur.sync2[c] == cur.sync3[c]) && !cur.sync3[c] && cur.cap_lvl[c];
        if (rise[c]) begin
          next_s.rising_capture_latch[c] = cur.cnt[c]; // R13
        end
        if (fall[c]) begin
          next_s.falling_capture_latch[c] = cur.cnt[c]; // R13
        end
        // Only enabled edges raise a flag.
        cap_evt[c] = (rise[c] && cur.cap_ctrl[c][CAP_RIE_BIT]) ||
                     (fall[c] && cur.cap_ctrl[c][CAP_FIE_BIT]); // R14
        set_flags[ST_RISE_LSB + c] = rise[c] && cur.cap_ctrl[c][CAP_RIE_BIT]; // R14
        set_flags[ST_FALL_LSB + c] = fall[c] && cur.cap_ctrl[c][CAP_FIE_BIT]; // R14
      end
    end

    // Period counters, double-buffered period and compare, and raw waveform.
    for (int c = 0; c < NUM_CH; c++) begin
      if (!cur.run[c]) begin
        next_s.armed[c]  = 1'b0;
        next_s.halted[c] = 1'b0;
        next_s.raw[c]    = 1'b0;
        next_s.cnt[c]    = '0;
      end else if (!cur.armed[c]) begin
        next_s.armed[c]               = 1'b1;
        next_s.cnt[c]                 = cur.period_buf[c];
        next_s.period_reload_value[c] = cur.period_buf[c];
        next_s.cmp_act[c]             = cur.cmp_buf[c];
      end else if (cap_evt[c]) begin
        next_s.cnt[c] = cur.period_reload_value[c]; // R15 R12
      end else if (ch_tick[c] && !cur.halted[c]) begin
        if (cur.cnt[c] == '0) begin
          set_flags[ST_ZERO_LSB + c]    = 1'b1;                // R4
          next_s.period_reload_value[c] = cur.period_buf[c];   // R10
          next_s.cmp_act[c]             = cur.cmp_buf[c];      // R10
          next_s.raw[c]                 = 1'b0;
          if (cur.auto_reload[c]) begin
            next_s.cnt[c] = cur.period_buf[c]; // R6
          end else begin
            next_s.halted[c] = 1'b1; // R7
          end
        end else begin
          if (cur.cnt[c] == cur.cmp_act[c]) begin
            next_s.raw[c] = 1'b1; // R11
          end
          next_s.cnt[c] = cur.cnt[c] - 16'h0001; // R3
        end
      end
    end

    // Pin drive: independent channels, or pairs with dead time from the even channel.
    for (int p = 0; p < NUM_GEN; p++) begin
      base = cur.raw[2*p];
      next_s.dz_prev[p] = base;
      if (cur.dz_en[p]) begin
        if (base != cur.dz_prev[p]) begin
          next_s.dz_cnt[p]      = cur.dead[p];  // R18
          next_s.pin_out[2*p]   = 1'b0;
          next_s.pin_out[2*p+1] = 1'b0;
        end else if (cur.dz_cnt[p] != '0) begin
          next_s.dz_cnt[p] = cur.dz_cnt[p] - 8'h01; // R18
        end else begin
          next_s.pin_out[2*p]   = base;  // R8 R9
          next_s.pin_out[2*p+1] = !base; // R18
        end
      end else begin
        next_s.dz_cnt[p]      = '0;
        next_s.pin_out[2*p]   = cur.raw[2*p];   // R1
        next_s.pin_out[2*p+1] = cur.raw[2*p+1]; // R1
      end
    end

    // Register writes in the data phase; address phase was registered earlier.
    if (wr) begin
      unique case (a)
        OFF_CTRL: begin
          next_s.dz_en       = hwdata[CTRL_DZ_LSB +: NUM_GEN]; // R8
          next_s.run         = hwdata[CTRL_RUN_LSB +: NUM_CH];
          next_s.auto_reload = hwdata[CTRL_AUTO_LSB +: NUM_CH];
        end
        OFF_PRESCALE: next_s.prescale = hwdata;
        OFF_CLKSEL: begin
          for (int c = 0; c < NUM_CH; c++) begin
            next_s.clk_sel[c] = hwdata[c*SEL_STRIDE +: SEL_W];
          end
        end
        OFF_DEAD: next_s.dead = hwdata;
        OFF_CAPCTL01, OFF_CAPCTL23: begin
          for (int c = 0; c < NUM_CH; c++) begin
            bit_pos = (c % 2) * CAP_ODD_SH + (c / 4) * CAP_GRP_SH;
            if (((c / 2) % 2) == int'(a == OFF_CAPCTL23)) begin
              next_s.cap_ctrl[c] = hwdata[bit_pos +: 3]; // R12 R14
            end
          end
        end
        OFF_STATUS: clr_flags = hwdata[STAT_W-1:0]; // R17
        OFF_MASK: next_s.mask = hwdata[STAT_W-1:0];
        default: begin
          if (a >= OFF_PERIOD0 && a < OFF_PER_END) begin
            if (a[CMP_BIT]) begin
              next_s.cmp_buf[pch] = hwdata[CNT_W-1:0]; // R10
            end else begin
              next_s.period_buf[pch] = hwdata[CNT_W-1:0]; // R10
            end
          end
        end
      endcase
    end

    // Sticky flags: a new event wins over a clear in the same cycle.
    next_s.status = (cur.status & ~clr_flags) | set_flags; // R17 R4

    // Read multiplexer; unmapped offsets read as zero.
    unique case (a)
      OFF_CTRL: begin
        rd_word[CTRL_DZ_LSB +: NUM_GEN]  = cur.dz_en;
        rd_word[CTRL_RUN_LSB +: NUM_CH]  = cur.run;
        rd_word[CTRL_AUTO_LSB +: NUM_CH] = cur.auto_reload;
      end
      OFF_PRESCALE: rd_word = cur.prescale;
      OFF_CLKSEL: begin
        for (int c = 0; c < NUM_CH; c++) begin
          rd_word[c*SEL_STRIDE +: SEL_W] = cur.clk_sel[c];
        end
      end
      OFF_DEAD: rd_word = cur.dead;
      OFF_CAPCTL01, OFF_CAPCTL23: begin
        for (int c = 0; c < NUM_CH; c++) begin
          bit_pos = (c % 2) * CAP_ODD_SH + (c / 4) * CAP_GRP_SH;
          if (((c / 2) % 2) == int'(a == OFF_CAPCTL23)) begin
            rd_word[bit_pos +: 3] = cur.cap_ctrl[c];
          end
        end
      end
      OFF_STATUS: rd_word[STAT_W-1:0] = cur.status;
      OFF_MASK: rd_word[STAT_W-1:0] = cur.mask;
      default: begin
        if (a >= OFF_PERIOD0 && a < OFF_PER_END) begin
          rd_word[CNT_W-1:0] = a[CMP_BIT] ? cur.cmp_buf[pch] : cur.period_buf[pch];
        end else if (a >= OFF_LATCH0 && a < OFF_LAT_END) begin
          rd_word = {cur.falling_capture_latch[lch], cur.rising_capture_latch[lch]};
        end
      end
    endcase

    // Reads take one wait cycle so the word is registered and any prior write has landed.
    if (cur.rd_pend) begin
      next_s.rdata   = rd_word;
      next_s.rd_pend = 1'b0;
    end
    if (hready) begin
      next_s.ap_valid = hsel && htrans[1];
      next_s.ap_write = hwrite;
      next_s.ap_addr  = haddr[ADDR_W-1:0];
      next_s.rd_pend  = hsel && htrans[1] && !hwrite;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Whole state resets to zero: channels stopped, pins driven low, flags clear.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur <= '0;
    end else begin
      cur <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // A channel in capture mode releases its pin; the interrupt follows unmasked flags.
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      pulse_oe_n[c]           = cur.cap_ctrl[c][CAP_EN_BIT]; // R12
      pulse_outputs_0_to_7[c] = cur.pin_out[c] && !cur.cap_ctrl[c][CAP_EN_BIT];
    end
  end

  assign irq       = |(cur.status & cur.mask); // R5
  assign hreadyout = !cur.rd_pend;
  assign hresp     = 1'b0;
  assign hrdata    = cur.rdata;

endmodule : pwm_gen_capture_timer

`default_nettype wire

/* hw/pwm_pkg.sv */
// Package with register map, field layout and sizes of the pulse generator and capture timer.
package pwm_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_CH   = 8;
  localparam int NUM_GEN  = 4;
  localparam int CNT_W    = 16;
  localparam int PRE_W    = 8;
  localparam int DEAD_W   = 8;
  localparam int DIV_W    = 4;
  localparam int SEL_W    = 3;
  localparam int ADDR_W   = 8;
  localparam int STAT_W   = 24;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00; // pulse_control_reg
  localparam logic [ADDR_W-1:0] OFF_PRESCALE = 8'h04; // Four 8-bit prescalers.
  localparam logic [ADDR_W-1:0] OFF_CLKSEL   = 8'h08; // Eight 3-bit divider selects, one per 4-bit field.
  localparam logic [ADDR_W-1:0] OFF_DEAD     = 8'h0c; // Four 8-bit dead times.
  localparam logic [ADDR_W-1:0] OFF_PERIOD0  = 8'h10; // Period of channel 0, stride 8.
  localparam logic [ADDR_W-1:0] OFF_PER_END  = 8'h50; // First offset past the period area.
  localparam logic [ADDR_W-1:0] OFF_CAPCTL01 = 8'h50; // capture_control_ch01
  localparam logic [ADDR_W-1:0] OFF_CAPCTL23 = 8'h54; // capture_control_ch23
  localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h58; // pulse_irq_indication
  localparam logic [ADDR_W-1:0] OFF_MASK     = 8'h5c; // Interrupt mask.
  localparam logic [ADDR_W-1:0] OFF_LATCH0   = 8'h60; // capture_latch_pair of channel 0.
  localparam logic [ADDR_W-1:0] OFF_LAT_END  = 8'h80;
  localparam int                CH_SHIFT     = 3;     // Period/compare stride is 8 bytes.
  localparam int                CMP_BIT      = 2;     // Address bit picking compare over period.
  localparam int                LAT_SHIFT    = 2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_DZ_LSB   = 4;  // pair01_deadzone_enable and the three further pairs.
  localparam int CTRL_RUN_LSB  = 8;
  localparam int CTRL_AUTO_LSB = 16;
  localparam int SEL_STRIDE    = 4;
  localparam int CAP_EN_BIT    = 0;
  localparam int CAP_RIE_BIT   = 1;
  localparam int CAP_FIE_BIT   = 2;
  localparam int CAP_ODD_SH    = 16; // Odd channel of a pair sits 16 bits up.
  localparam int CAP_GRP_SH    = 8;  // Second group of four sits 8 bits up.
  localparam int ST_ZERO_LSB   = 0;
  localparam int ST_RISE_LSB   = 8;
  localparam int ST_FALL_LSB   = 16;

  // ----------------------------------------------------------------
  // Divider selects
  // ----------------------------------------------------------------
  localparam logic [SEL_W-1:0] DIV_MAX_SEL = 3'h4; // Divide by 16.

endpackage : pwm_pkg

/* verification/pwm_chk_asserts.sv */
// Checker of bus timing, pin gating, interrupt and pair rules.
`timescale 1ns/1ps
`default_nettype none
module pwm_chk
  import pwm_pkg::*;
(
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [2:0]        hsize,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  input wire logic              hreadyout,
  input wire logic              hresp,
  input wire logic [31:0]       hrdata,
  input wire logic [NUM_CH-1:0] capture_in,
  input wire logic [NUM_CH-1:0] pulse_outputs_0_to_7,
  input wire logic [NUM_CH-1:0] pulse_oe_n,
  input wire logic              irq
);
  typedef struct packed {
    logic       wph;
    logic       wctl;
    logic       rd1;
    logic [3:0] dz;
    logic [3:0] dzq;
  } chk_s;
  chk_s st;
  wire  take = hsel && htrans[1] && hready;
  // Follows data phases and the pair enables, so pair checks start once enables settle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st.rd1 <= take && !hwrite;
      st.dzq <= st.dz;
      st.wph <= (take && hwrite) || (st.wph && !hready);
      if (take && hwrite) st.wctl <= (haddr[7:0] == OFF_CTRL);
      if (st.wph && hready && st.wctl) st.dz <= hwdata[CTRL_DZ_LSB +: 4];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not OKAY");
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  a_wait_single: assert property (!hreadyout |=> hreadyout) else $error("wait too long");
  a_rdata_hold: assert property ($changed(hrdata) |-> st.rd1 || $past(st.rd1))
    else $error("hrdata changed outside a read");
  a_pin_gated: assert property ((pulse_outputs_0_to_7 & pulse_oe_n) == '0)
    else $error("capture pin driven high");
  a_irq_clear: assert property ($fell(irq) |-> $past(st.wph))
    else $error("irq fell without a write");
  for (genvar p = 0; p < 4; p++) begin : g_pair
    a_pair_excl: assert property (st.dz[p] && st.dzq[p] |->
      !(pulse_outputs_0_to_7[2*p] && pulse_outputs_0_to_7[2*p+1]))
      else $error("pair outputs high together");
  end
endmodule : pwm_chk
bind pwm_gen_capture_timer pwm_chk u_pwm_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .capture_in(capture_in), .pulse_outputs_0_to_7(pulse_outputs_0_to_7),
  .pulse_oe_n(pulse_oe_n), .irq(irq));
`default_nettype wire

/* verification/pwm_far_side.sv */
// Model of the power stage and capture source beyond the pins.
`timescale 1ns/1ps
`default_nettype none
module pwm_far_side (
  input  wire logic [7:0] pins_out,
  input  wire logic [7:0] pins_oe_n,
  input  wire logic       hclk,
  output logic      [7:0] pins_in
);
  logic [7:0] drv = 8'h00;
  logic [7:0] prev = 8'h00;
  int         rises [8];
  // A pin shows the device level while driven and the source level while it listens.
  assign pins_in = (pins_oe_n & drv) | (~pins_oe_n & pins_out);
  // Counts rising edges seen by the power stage on every output.
  always @(posedge hclk) begin
    prev <= pins_out;
    for (int i = 0; i < 8; i++) begin
      if (pins_out[i] && !prev[i]) rises[i]++;
    end
  end
  // Moves one source line just after a clock edge.
  task automatic pin(input int ch, input logic v);
    @(posedge hclk);
    drv[ch] <= v;
  endtask : pin
  // Clears the edge counts.
  task automatic clear();
    for (int i = 0; i < 8; i++) rises[i] = 0;
  endtask : clear
endmodule : pwm_far_side
`default_nettype wire

/* verification/tb_pwm_gen_capture_timer.sv */
// Testbench: bus access, timer modes, divider, capture and dead zone.
`timescale 1ns/1ps
`default_nettype none
module tb_pwm_gen_capture_timer
  import pwm_pkg::*;
;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = '0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic [7:0]  cap_in;
  logic [7:0]  pouts;
  logic [7:0]  oe_n;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          cycles = 0;
  always #50 hclk = ~hclk;
  pwm_gen_capture_timer u_pwm_gen_capture_timer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .capture_in(cap_in), .pulse_outputs_0_to_7(pouts), .pulse_oe_n(oe_n), .irq(irq));
  pwm_far_side u_pwm_far_side (.pins_out(pouts), .pins_oe_n(oe_n), .hclk(hclk), .pins_in(cap_in));
  task automatic summarize();
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask : chk
  // One single transfer; holds each phase until hready is sampled high.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic chan(input int c, input logic [15:0] per, input logic [15:0] cmp);
    bus(1'b1, OFF_PERIOD0 + 8'(c << CH_SHIFT), {16'h0, per});
    bus(1'b1, OFF_PERIOD0 + 8'(c << CH_SHIFT) + 8'h04, {16'h0, cmp});
  endtask : chan
  task automatic t_reset();
    chk("hreadyout", 32'h1, {31'h0, hreadyout});
    chk("irq_reset", 32'h0, {31'h0, irq});
    bus(1'b0, OFF_STATUS, '0);
    chk("status_reset", 32'h0, q);
    bus(1'b1, OFF_LATCH0, 32'hffff_ffff);
    bus(1'b0, OFF_LATCH0, '0);
    chk("latch_read_only", 32'h0, q);
    bus(1'b0, OFF_LAT_END, '0);
    chk("unmapped", 32'h0, q);
  endtask : t_reset
  task automatic t_modes();
    chan(0, 16'h4, 16'h1);
    chan(1, 16'h3, 16'h1);
    bus(1'b1, OFF_MASK, 32'h3);
    u_pwm_far_side.clear();
    bus(1'b1, OFF_CTRL, 32'h0001_0300);
    repeat (80) @(posedge hclk);
    chk("auto_rises", 32'h1, {31'h0, u_pwm_far_side.rises[0] >= 5});
    chk("oneshot_rises", 32'h1, 32'(u_pwm_far_side.rises[1]));
    bus(1'b0, OFF_STATUS, '0);
    chk("zero_flags", 32'h3, q & 32'hff);
    chk("irq_on", 32'h1, {31'h0, irq});
    bus(1'b1, OFF_MASK, 32'h0);
    @(posedge hclk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    bus(1'b1, OFF_STATUS, 32'h3);
    repeat (40) @(posedge hclk);
    bus(1'b0, OFF_STATUS, '0);
    chk("oneshot_once", 32'h1, q & 32'h3);
    bus(1'b1, OFF_CTRL, 32'h0);
  endtask : t_modes
  task automatic t_compare();
    chan(2, 16'h5, 16'hffff);
    chan(3, 16'h5, 16'h2);
    u_pwm_far_side.clear();
    bus(1'b1, OFF_CTRL, 32'h000c_0c00);
    repeat (60) @(posedge hclk);
    chk("no_match_rises", 32'h0, 32'(u_pwm_far_side.rises[2]));
    chk("match_rises", 32'h1, {31'h0, u_pwm_far_side.rises[3] >= 5});
    chan(3, 16'h5, 16'hffff);
    u_pwm_far_side.clear();
    repeat (60) @(posedge hclk);
    chk("buffered_cmp", 32'h1, {31'h0, u_pwm_far_side.rises[3] <= 1});
  endtask : t_compare
  task automatic t_divider();
    bus(1'b1, OFF_CLKSEL, 32'h0000_0400);
    chan(2, 16'h3, 16'h1);
    chan(3, 16'h3, 16'h1);
    repeat (200) @(posedge hclk);
    u_pwm_far_side.clear();
    repeat (320) @(posedge hclk);
    chk("slow_rises", 32'h1, {31'h0, u_pwm_far_side.rises[2] >= 2});
    chk("ratio", 32'h1, {31'h0, u_pwm_far_side.rises[3] >= 8 * u_pwm_far_side.rises[2]});
    bus(1'b1, OFF_PRESCALE, 32'h0000_0100);
    repeat (20) @(posedge hclk);
    u_pwm_far_side.clear();
    repeat (160) @(posedge hclk);
    chk("prescaled", 32'h1, {31'h0, u_pwm_far_side.rises[3] inside {[19:21]}});
    bus(1'b1, OFF_CTRL, 32'h0);
  endtask : t_divider
  task automatic t_capture();
    logic [15:0] fall;
    chan(4, 16'h0100, 16'h0);
    bus(1'b1, OFF_CTRL, 32'h0010_1000);
    bus(1'b1, OFF_CAPCTL01, 32'h0000_0300);
    bus(1'b1, OFF_MASK, 32'h0010_1000);
    chk("oe_capture", 32'h1, {31'h0, oe_n[4]});
    u_pwm_far_side.pin(4, 1'b1);
    repeat (20) @(posedge hclk);
    u_pwm_far_side.pin(4, 1'b0);
    repeat (8) @(posedge hclk);
    bus(1'b0, OFF_STATUS, '0);
    chk("rise_flag_only", 32'h0000_1000, q & 32'h0010_1000);
    chk("irq_capture", 32'h1, {31'h0, irq});
    bus(1'b0, OFF_LATCH0 + 8'h10, '0);
    fall = q[31:16];
    chk("fall_latch", 32'h1, {31'h0, fall >= 16'hea && fall <= 16'hee});
    bus(1'b1, OFF_STATUS, 32'h0000_1000);
    bus(1'b0, OFF_STATUS, '0);
    chk("w1c", 32'h0, q & 32'h0010_1000);
    chk("irq_clear", 32'h0, {31'h0, irq});
    bus(1'b1, OFF_CAPCTL01, 32'h0000_0500);
    u_pwm_far_side.pin(4, 1'b1);
    repeat (8) @(posedge hclk);
    u_pwm_far_side.pin(4, 1'b0);
    repeat (8) @(posedge hclk);
    bus(1'b0, OFF_STATUS, '0);
    chk("fall_flag_only", 32'h0010_0000, q & 32'h0010_1000);
    bus(1'b1, OFF_CTRL, 32'h0);
  endtask : t_capture
  task automatic t_dead();
    int both_low;
    both_low = 0;
    bus(1'b1, OFF_DEAD, 32'h0000_0003);
    bus(1'b1, OFF_CTRL, 32'h0000_0010);
    chan(0, 16'd20, 16'd10);
    chan(1, 16'd7, 16'd2);
    bus(1'b1, OFF_CTRL, 32'h0001_0110);
    u_pwm_far_side.clear();
    repeat (200) begin
      @(posedge hclk);
      both_low += (pouts[1:0] == 2'b00);
    end
    chk("even_rises", 32'h1, {31'h0, u_pwm_far_side.rises[0] >= 5});
    chk("odd_follows", 32'h1,
        {31'h0, (u_pwm_far_side.rises[0] - u_pwm_far_side.rises[1]) inside {-1, 0, 1}});
    chk("dead_bands", 32'h1, {31'h0, both_low >= 40});
    bus(1'b1, OFF_CTRL, 32'h0);
  endtask : t_dead
  // Cuts a hang short.
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      summarize();
    end
  end
  // Main sequence.
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_modes();
    t_compare();
    t_divider();
    t_capture();
    t_dead();
    summarize();
  end
endmodule : tb_pwm_gen_capture_timer
`default_nettype wire
